// ===== hw/crt_cfg.svh
`ifndef CRT_CFG_SVH
`define CRT_CFG_SVH
`default_nettype none
// register byte offsets
`define CRT_OFS_CMD      12'h000
`define CRT_OFS_FMT0     12'h004
`define CRT_OFS_FMT1     12'h008
`define CRT_OFS_CURSOR   12'h00c
`define CRT_OFS_LPEN     12'h010
`define CRT_OFS_STATUS   12'h014
// reset values and writable-bit masks
`define CRT_FMT0_RST     32'h50180f50
`define CRT_FMT0_MASK    32'h7f3f1f7f
`define CRT_FMT1_RST     32'h000f0310
`define CRT_FMT1_MASK    32'h00ff077f
// buffer limits
`define CRT_ROW_MAX      7'h50
`define CRT_ATTR_MAX     5'h14
// attribute modes
`define CRT_MODE_T_COLOR 2'h0
`define CRT_MODE_T_MONO  2'h1
`define CRT_MODE_NT_MONO 2'h2
// command opcodes, cmd word bits 2:0
`define CRT_CMD_RESET    3'h0
`define CRT_CMD_STOP     3'h1
`define CRT_CMD_START    3'h2
`define CRT_CMD_CURSOR   3'h3
`define CRT_CMD_READ_LP  3'h4
`define CRT_CMD_RST_CNT  3'h5
`define CRT_CMD_RST_INT  3'h6
`define CRT_CMD_INT_MASK 3'h7
`default_nettype wire
`endif

// ===== hw/crt_pkg.sv
`default_nettype none
package crt_pkg;
  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } apb_req_type;
  typedef struct packed {
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } apb_rsp_type;
  typedef struct packed {
    logic       pad31;
    logic [4:0] attrs_per_row;
    logic [1:0] attr_mode;
    logic [1:0] pad23;
    logic [5:0] rows_m1;
    logic [2:0] pad15;
    logic [4:0] lines_m1;
    logic       pad7;
    logic [6:0] chars_per_row;
  } fmt0_type;
  typedef struct packed {
    logic [7:0] pad31;
    logic [7:0] blink_m1;
    logic [4:0] pad15;
    logic [2:0] vretrace_rows;
    logic       pad7;
    logic [6:0] hretrace_chars;
  } fmt1_type;
  typedef struct packed {
    logic [1:0] spare;
    logic       general;
    logic       slit12;
    logic       slit0;
    logic       suppress;
    logic       reverse;
    logic       highlight;
  } attr_type;
  typedef enum logic [1:0] {fill_idle, fill_chars, fill_attrs}
    fill_state_type;
endpackage : crt_pkg
`default_nettype wire

// ===== hw/crt_row_buffer_video_timing.sv
//
// Overview of operation
// - character counter spans each row, limited by characters-per-row plus retrace length
// - two 80-entry row buffers, one shown while the other fills
// - each character clock one displayed entry goes to char_code_out
// - dma bytes go into fill buffer, stopping at characters-per-row
// - attribute and control codes go to attribute queue, up to limit
// - attribute codes leave the displayed queue in order to video logic
// - non-transparent mode separates attribute codes from characters
// - attribute queue is two buffers of 20 entries each
// - a read flag on a character pops one attribute and applies it
// - next row attributes load by dma into the other attribute buffer
// - raster line counter per row, low four bits on raster_line_count_out
// - horizontal retrace from character count for programmed length
// - row counter drives vertical retrace for programmed row count
// - attribute outputs follow the attribute code in effect
// - cursor at programmed address, gated by blink timing
// - light pen edge latches current row and column
// - read light pen command returns latched position to software
// - character codes address an external character generator
// - up to 32 raster lines per character row
// - up to 64 character rows per frame
// - eight host commands, some carrying parameter fields
// - three attribute modes: colour, mono, non-transparent mono
//
// Design decisions made here: the APB slave port and the address map.
`include "crt_cfg.svh"
`default_nettype none
module crt_row_buffer_video_timing (
  input  wire logic                 clk,
  input  wire logic                 srst,
  input  wire crt_pkg::apb_req_type apb_req,
  output var crt_pkg::apb_rsp_type  apb_rsp,
  input  wire logic [7:0]           dma_data_in,
  input  wire logic                 dma_strobe_in,
  input  wire logic                 dma_grant_in,
  output logic                      dma_request_out,
  input  wire logic                 light_pen_in,
  output logic [7:0]                char_code_out,
  output logic [3:0]                raster_line_count_out,
  output logic                      horiz_retrace_out,
  output logic                      vert_retrace_out,
  output logic                      cursor_out,
  output logic                      highlight_out,
  output logic                      reverse_video_out,
  output logic                      video_suppress_out,
  output logic                      slit_line_zero_out,
  output logic                      slit_line_twelve_out,
  output logic                      general_attr_out
);
  //////////////////////////////////////////////////////////////////////
  // pin synchronisers
  logic [10:0] sync1_q;
  logic [10:0] sync2_q;
  logic [1:0]  prev_q;
  always_ff @(posedge clk) begin
    if (srst) begin
      sync1_q <= 11'h000;
      sync2_q <= 11'h000;
      prev_q  <= 2'h0;
    end else begin
      sync1_q <= {light_pen_in, dma_strobe_in, dma_grant_in, dma_data_in};
      sync2_q <= sync1_q;
      prev_q  <= sync2_q[10:9];
    end
  end
  crt_pkg::fill_state_type fill_q;
  wire logic [7:0] dma_data = sync2_q[7:0];
  wire logic lp_rise = sync2_q[10] & ~prev_q[1];
  wire logic dma_wr  = sync2_q[9] & ~prev_q[0] & sync2_q[8] &
                       (fill_q != crt_pkg::fill_idle);
  //////////////////////////////////////////////////////////////////////
  // register decode
  crt_pkg::fmt0_type fmt0_q;
  crt_pkg::fmt1_type fmt1_q;
  wire logic [11:0] addr = apb_req.paddr;
  wire logic [31:0] wdat = apb_req.pwdata;
  wire logic access = apb_req.psel & apb_req.penable;
  wire logic bus_wr = access & apb_req.pwrite;
  wire logic addr_ok = (addr == `CRT_OFS_CMD) | (addr == `CRT_OFS_FMT0) |
                       (addr == `CRT_OFS_FMT1) |
                       (addr == `CRT_OFS_CURSOR) |
                       (addr == `CRT_OFS_LPEN) | (addr == `CRT_OFS_STATUS);
  wire logic cmd_hit = bus_wr & (addr == `CRT_OFS_CMD);
  wire logic [2:0] op = wdat[2:0];
  wire logic cmd_reset  = cmd_hit & (op == `CRT_CMD_RESET);
  wire logic cmd_stop   = cmd_hit & (op == `CRT_CMD_STOP);
  wire logic cmd_start  = cmd_hit & (op == `CRT_CMD_START);
  wire logic cmd_cursor = cmd_hit & (op == `CRT_CMD_CURSOR);
  wire logic cmd_rd_lp  = cmd_hit & (op == `CRT_CMD_READ_LP);
  wire logic cmd_rstcnt = cmd_hit & (op == `CRT_CMD_RST_CNT);
  wire logic cmd_rstint = cmd_hit & (op == `CRT_CMD_RST_INT);
  wire logic cmd_mask   = cmd_hit & (op == `CRT_CMD_INT_MASK);
  wire logic cnt_clr    = cmd_reset | cmd_rstcnt;
  // format fields, clamped to buffer sizes
  wire logic [6:0] cpr = (fmt0_q.chars_per_row > `CRT_ROW_MAX) ?
                         `CRT_ROW_MAX : fmt0_q.chars_per_row;
  wire logic [4:0] apr = (fmt0_q.attrs_per_row > `CRT_ATTR_MAX) ?
                         `CRT_ATTR_MAX : fmt0_q.attrs_per_row;
  wire logic nontransp = (fmt0_q.attr_mode == `CRT_MODE_NT_MONO);
  //////////////////////////////////////////////////////////////////////
  // character, line and row counters
  logic [7:0] char_q;
  logic [4:0] line_q;
  logic [6:0] row_q;
  wire logic [7:0] h_total_m1 = {1'b0, cpr} +
                                {1'b0, fmt1_q.hretrace_chars} - 8'h01;
  wire logic [6:0] v_total_m1 = {1'b0, fmt0_q.rows_m1} +
                                {4'h0, fmt1_q.vretrace_rows};
  wire logic char_last = (char_q == h_total_m1);
  wire logic line_last = (line_q == fmt0_q.lines_m1);
  wire logic row_last  = (row_q == v_total_m1);
  wire logic row_end   = char_last & line_last;
  wire logic frame_end = row_end & row_last;
  wire logic active_h  = (char_q < {1'b0, cpr});
  wire logic active_v  = (row_q <= {1'b0, fmt0_q.rows_m1});
  always_ff @(posedge clk) begin
    if (srst | cnt_clr) begin
      char_q <= 8'h00;
      line_q <= 5'h00;
      row_q  <= 7'h00;
    end else begin
      char_q <= char_last ? 8'h00 : char_q + 8'h01;
      if (char_last)
        line_q <= line_last ? 5'h00 : line_q + 5'h01;
      if (row_end)
        row_q <= row_last ? 7'h00 : row_q + 7'h01;
    end
  end
  //////////////////////////////////////////////////////////////////////
  // ping-pong row and attribute buffers
  logic [7:0] row_mem  [2][80];
  logic [7:0] attr_mem [2][20];
  logic [4:0] attr_cnt_q [2];
  logic       disp_q;
  logic       on_q;
  logic [6:0] fill_idx_q;
  logic [4:0] attr_wr_q;
  wire logic fill_sel  = ~disp_q;
  wire logic fill_last = (fill_idx_q == cpr - 7'h01);
  wire logic go_attr   = ~nontransp & (apr != 5'h00);
  wire logic nt_attr   = (fill_q == crt_pkg::fill_chars) & nontransp &
                         dma_data[7] & (attr_wr_q < apr);
  wire logic attr_we   = dma_wr & ((fill_q == crt_pkg::fill_attrs) |
                                   nt_attr);
  always_ff @(posedge clk) begin
    if (srst | cnt_clr)
      disp_q <= 1'b0;
    else if (row_end)
      disp_q <= ~disp_q;
  end
  always_ff @(posedge clk) begin
    if (srst | cmd_reset) begin
      fill_q        <= crt_pkg::fill_idle;
      fill_idx_q    <= 7'h00;
      attr_wr_q     <= 5'h00;
      attr_cnt_q[0] <= 5'h00;
      attr_cnt_q[1] <= 5'h00;
    end else if (row_end & on_q) begin
      fill_q             <= crt_pkg::fill_chars;
      fill_idx_q         <= 7'h00;
      attr_wr_q          <= 5'h00;
      attr_cnt_q[disp_q] <= 5'h00;
    end else begin
      if (attr_we) begin
        attr_wr_q            <= attr_wr_q + 5'h01;
        attr_cnt_q[fill_sel] <= attr_wr_q + 5'h01;
      end
      unique case (fill_q)
        crt_pkg::fill_idle: begin
        end
        crt_pkg::fill_chars: begin
          if (dma_wr) begin
            fill_idx_q <= fill_idx_q + 7'h01;
            if (fill_last)
              fill_q <= go_attr ? crt_pkg::fill_attrs :
                                  crt_pkg::fill_idle;
          end
        end
        crt_pkg::fill_attrs: begin
          if (dma_wr & (attr_wr_q == apr - 5'h01))
            fill_q <= crt_pkg::fill_idle;
        end
        default: fill_q <= crt_pkg::fill_idle;
      endcase
    end
  end
  always_ff @(posedge clk) begin
    if (dma_wr & (fill_q == crt_pkg::fill_chars))
      row_mem[fill_sel][fill_idx_q] <= dma_data;
    if (attr_we)
      attr_mem[fill_sel][attr_wr_q] <= dma_data;
  end
  assign dma_request_out = (fill_q != crt_pkg::fill_idle);
  //////////////////////////////////////////////////////////////////////
  // display read and attribute queue pop
  logic [4:0]        rd_idx_q;
  crt_pkg::attr_type attr_q;
  wire logic [6:0] row_idx = active_h ? char_q[6:0] : 7'h00;
  wire logic [7:0] rd_char = row_mem[disp_q][row_idx];
  wire logic [7:0] attr_rd = attr_mem[disp_q][rd_idx_q];
  wire logic shown = on_q & active_h & active_v;
  wire logic pop   = shown & rd_char[7] &
                     (rd_idx_q < attr_cnt_q[disp_q]);
  wire logic nt_code = nontransp & rd_char[7];
  wire crt_pkg::attr_type eff = pop ? crt_pkg::attr_type'(attr_rd) : attr_q;
  always_ff @(posedge clk) begin
    if (srst | char_last) begin
      rd_idx_q <= 5'h00;
      attr_q   <= crt_pkg::attr_type'(8'h00);
    end else if (pop) begin
      rd_idx_q <= rd_idx_q + 5'h01;
      attr_q   <= crt_pkg::attr_type'(attr_rd);
    end
  end
  //////////////////////////////////////////////////////////////////////
  // cursor, blink, control and light pen
  logic [6:0] cur_col_q;
  logic [5:0] cur_row_q;
  logic [7:0] blink_cnt_q;
  logic       blink_q;
  logic       frame_flag_q;
  logic [1:0] int_mask_q;
  logic [6:0] lp_col_q;
  logic [5:0] lp_row_q;
  logic       lp_pend_q;
  logic [6:0] lp_rd_col_q;
  logic [5:0] lp_rd_row_q;
  logic       lp_rd_valid_q;
  wire logic cursor_hit = shown & (char_q[6:0] == cur_col_q) &
                          (row_q == {1'b0, cur_row_q}) & blink_q;
  always_ff @(posedge clk) begin
    if (srst | cmd_reset) begin
      on_q         <= 1'b0;
      cur_col_q    <= 7'h00;
      cur_row_q    <= 6'h00;
      blink_cnt_q  <= 8'h00;
      blink_q      <= 1'b1;
      frame_flag_q <= 1'b0;
      int_mask_q   <= 2'h0;
    end else begin
      if (cmd_start)
        on_q <= 1'b1;
      else if (cmd_stop)
        on_q <= 1'b0;
      if (cmd_cursor) begin
        cur_col_q <= wdat[14:8];
        cur_row_q <= wdat[21:16];
      end
      if (cmd_mask)
        int_mask_q <= wdat[9:8];
      if (frame_end) begin
        blink_cnt_q <= (blink_cnt_q == fmt1_q.blink_m1) ? 8'h00 :
                       blink_cnt_q + 8'h01;
        if (blink_cnt_q == fmt1_q.blink_m1)
          blink_q <= ~blink_q;
      end
      frame_flag_q <= frame_end | (frame_flag_q & ~cmd_rstint);
    end
  end
  always_ff @(posedge clk) begin
    if (srst) begin
      lp_col_q      <= 7'h00;
      lp_row_q      <= 6'h00;
      lp_pend_q     <= 1'b0;
      lp_rd_col_q   <= 7'h00;
      lp_rd_row_q   <= 6'h00;
      lp_rd_valid_q <= 1'b0;
    end else begin
      if (lp_rise) begin
        lp_col_q <= char_q[6:0];
        lp_row_q <= row_q[5:0];
      end
      lp_pend_q <= lp_rise | (lp_pend_q & ~cmd_rd_lp);
      if (cmd_rd_lp) begin
        lp_rd_col_q   <= lp_col_q;
        lp_rd_row_q   <= lp_row_q;
        lp_rd_valid_q <= lp_pend_q;
      end
    end
  end
  //////////////////////////////////////////////////////////////////////
  // video outputs, all registered
  always_ff @(posedge clk) begin
    if (srst) begin
      char_code_out         <= 8'h00;
      raster_line_count_out <= 4'h0;
      horiz_retrace_out     <= 1'b0;
      vert_retrace_out      <= 1'b0;
      cursor_out            <= 1'b0;
      highlight_out         <= 1'b0;
      reverse_video_out     <= 1'b0;
      video_suppress_out    <= 1'b1;
      slit_line_zero_out    <= 1'b0;
      slit_line_twelve_out  <= 1'b0;
      general_attr_out      <= 1'b0;
    end else begin
      char_code_out <= (shown & ~nt_code) ? rd_char : 8'h00;
      raster_line_count_out <= line_q[3:0];
      horiz_retrace_out     <= ~active_h;
      vert_retrace_out      <= ~active_v;
      cursor_out            <= cursor_hit;
      highlight_out         <= shown & eff.highlight;
      reverse_video_out     <= shown & eff.reverse;
      video_suppress_out    <= ~shown | eff.suppress | nt_code;
      slit_line_zero_out    <= shown & eff.slit0;
      slit_line_twelve_out  <= shown & eff.slit12;
      general_attr_out      <= shown & eff.general;
    end
  end
  //////////////////////////////////////////////////////////////////////
  // apb slave
  logic [31:0] prdata_q;
  wire logic [31:0] rd_mux =
    (addr == `CRT_OFS_FMT0)   ? 32'(fmt0_q) :
    (addr == `CRT_OFS_FMT1)   ? 32'(fmt1_q) :
    (addr == `CRT_OFS_CURSOR) ? {10'h000, cur_row_q, 1'b0, cur_col_q,
                                 8'h00} :
    (addr == `CRT_OFS_LPEN)   ? {15'h0000, lp_rd_valid_q, 2'h0,
                                 lp_rd_row_q, 1'b0, lp_rd_col_q} :
    (addr == `CRT_OFS_STATUS) ? {26'h0000000, lp_pend_q, dma_request_out,
                                 int_mask_q, frame_flag_q, on_q} :
                                32'h00000000;
  always_ff @(posedge clk) begin
    if (srst) begin
      prdata_q <= 32'h00000000;
      fmt0_q   <= crt_pkg::fmt0_type'(`CRT_FMT0_RST);
      fmt1_q   <= crt_pkg::fmt1_type'(`CRT_FMT1_RST);
    end else begin
      if (apb_req.psel & ~apb_req.penable)
        prdata_q <= rd_mux;
      if (bus_wr & (addr == `CRT_OFS_FMT0))
        fmt0_q <= crt_pkg::fmt0_type'(wdat & `CRT_FMT0_MASK);
      if (bus_wr & (addr == `CRT_OFS_FMT1))
        fmt1_q <= crt_pkg::fmt1_type'(wdat & `CRT_FMT1_MASK);
    end
  end
  // one driver for the whole response word
  assign apb_rsp = '{prdata:  prdata_q,
                     pready:  1'b1,
                     pslverr: access & ~addr_ok};
  //////////////////////////////////////////////////////////////////////
  // assertions
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  a_char_wrap: assert property (char_last & ~cnt_clr |=> char_q == 8'h00)
    else $error("character counter did not wrap");
  a_line_step: assert property (char_last & ~line_last & ~cnt_clr
    |=> line_q == $past(line_q) + 5'h01)
    else $error("line counter did not advance");
  a_row_swap: assert property (row_end & ~cnt_clr
    |=> disp_q != $past(disp_q))
    else $error("buffers did not swap at row end");
  a_fill_request: assert property (row_end & on_q & ~cnt_clr
    |=> dma_request_out && fill_idx_q == 7'h00)
    else $error("no fill request after swap");
  a_fill_stop: assert property (fill_q == crt_pkg::fill_chars & dma_wr &
    fill_last & ~go_attr & ~(row_end & on_q) & ~cmd_reset
    |=> !dma_request_out)
    else $error("fill ran past characters per row");
  a_attr_limit: assert property (attr_wr_q <= apr ||
    $changed(fmt0_q))
    else $error("attribute queue exceeded limit");
  a_retrace_out: assert property (##1 (horiz_retrace_out ==
    $past(char_q >= {1'b0, cpr})) && (vert_retrace_out ==
    $past(row_q > {1'b0, fmt0_q.rows_m1})))
    else $error("retrace outputs misaligned");
  a_pop_apply: assert property (pop & ~char_last |=> highlight_out ==
    $past(attr_rd[0]) && rd_idx_q == $past(rd_idx_q) + 5'h01)
    else $error("popped attribute not applied");
  a_cursor_pos: assert property (cursor_out |-> $past(char_q[6:0]) ==
    cur_col_q || $past(cmd_cursor))
    else $error("cursor at wrong column");
  a_stop_blank: assert property (!on_q ##1 !on_q |-> video_suppress_out
    && char_code_out == 8'h00)
    else $error("video not suppressed while stopped");
  a_lpen_latch: assert property (lp_rise |=> lp_pend_q &&
    lp_col_q == $past(char_q[6:0]) && lp_row_q == $past(row_q[5:0]))
    else $error("light pen position not latched");
  a_lpen_read: assert property (cmd_rd_lp |=> lp_rd_col_q ==
    $past(lp_col_q) && lp_rd_valid_q == $past(lp_pend_q))
    else $error("light pen read returned wrong value");
  c_frame_end: cover property (frame_end & on_q);
  c_fill_done: cover property (dma_request_out ##1 !dma_request_out);
  c_attr_pop: cover property (pop ##1 pop);
  c_lpen_hit: cover property (lp_rise ##[1:20] cmd_rd_lp);
endmodule : crt_row_buffer_video_timing
`default_nettype wire

// ===== bench/crt_dma_partner.sv
`default_nettype none
module crt_dma_partner (
  input  wire logic       clk,
  input  wire logic       srst,
  input  wire logic       dma_request_out,
  input  wire logic       slow,
  input  wire logic [7:0] code_base,
  input  wire logic [7:0] attr_code,
  output logic [7:0]      dma_data_in,
  output logic            dma_strobe_in,
  output logic            dma_grant_in
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [3:0] phase_q;
  logic [7:0] idx_q;
  wire  [3:0] last_phase = slow ? 4'hf : 4'h9;
  //////////////////////////////////////////////////////////////////////////
  // one byte per strobe, data held well before and after each strobe
  always_ff @(posedge clk) begin
    if (srst || !dma_request_out) begin
      phase_q       <= 4'h0;
      idx_q         <= 8'h00;
      dma_strobe_in <= 1'b0;
      dma_grant_in  <= 1'b0;
      // released bus shows the inverse, never a stale value
      if (srst) dma_data_in <= 8'h00;
      else if (dma_grant_in) dma_data_in <= ~dma_data_in;
    end else begin
      dma_grant_in  <= 1'b1;
      phase_q       <= (phase_q == last_phase) ? 4'h0 : phase_q + 4'h1;
      dma_strobe_in <= (phase_q >= 4'h4) && (phase_q < 4'h7);
      // fifth byte of a fill is the attribute byte
      if (phase_q == 4'h0)
        dma_data_in <= (idx_q == 8'h04) ? attr_code : code_base + idx_q;
      if (phase_q == 4'h9) idx_q <= idx_q + 8'h01;
    end
  end
endmodule : crt_dma_partner
`default_nettype wire

// ===== bench/crt_row_buffer_video_timing_tb_top.sv
`default_nettype none
module crt_row_buffer_video_timing_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  logic                 clk = 1'b0;
  logic                 srst = 1'b1;
  logic                 slow = 1'b0;
  logic                 light_pen_in = 1'b0;
  crt_pkg::apb_req_type apb_req = '0;
  crt_pkg::apb_rsp_type apb_rsp;
  logic [7:0]           dma_data_in, char_code_out;
  logic                 dma_strobe_in, dma_grant_in, dma_request_out;
  logic [3:0]           raster_line_count_out;
  logic                 horiz_retrace_out, vert_retrace_out, cursor_out;
  logic                 highlight_out, reverse_video_out, video_suppress_out;
  logic                 slit_line_zero_out, slit_line_twelve_out;
  logic                 general_attr_out;
  logic [7:0]           code_base = 8'h41;
  logic [7:0]           attr_code = 8'h00;
  logic [31:0]          rd_q;
  logic                 err_q;
  int                   n_fail = 0;
  int                   samples_checked = 0;
  always #2.5 clk = ~clk;
  crt_row_buffer_video_timing crt_row_buffer_video_timing_inst (
    .clk(clk), .srst(srst), .apb_req(apb_req), .apb_rsp(apb_rsp),
    .dma_data_in(dma_data_in), .dma_strobe_in(dma_strobe_in),
    .dma_grant_in(dma_grant_in), .dma_request_out(dma_request_out),
    .light_pen_in(light_pen_in), .char_code_out(char_code_out),
    .raster_line_count_out(raster_line_count_out),
    .horiz_retrace_out(horiz_retrace_out),
    .vert_retrace_out(vert_retrace_out), .cursor_out(cursor_out),
    .highlight_out(highlight_out), .reverse_video_out(reverse_video_out),
    .video_suppress_out(video_suppress_out),
    .slit_line_zero_out(slit_line_zero_out),
    .slit_line_twelve_out(slit_line_twelve_out),
    .general_attr_out(general_attr_out));
  crt_dma_partner crt_dma_partner_inst (
    .clk(clk), .srst(srst), .dma_request_out(dma_request_out),
    .slow(slow), .code_base(code_base), .attr_code(attr_code),
    .dma_data_in(dma_data_in),
    .dma_strobe_in(dma_strobe_in), .dma_grant_in(dma_grant_in));
  //////////////////////////////////////////////////////////////////////////
  task fail(input string m);
    n_fail++;
    $display("unexpected at %0t: %s", $time, m);
  endtask : fail
  task timeout(input string m);
    fail(m);
    finish_test();
  endtask : timeout
  task cmp(input logic [31:0] got, input logic [31:0] exp, input string m);
    samples_checked++;
    if (got !== exp) fail(m);
  endtask : cmp
  task finish_test;
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : finish_test
  // request held until pready is seen high at a rising edge
  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] d);
    int   n;
    logic rdy;
    @(posedge clk);
    apb_req.psel    <= 1'b1;
    apb_req.penable <= 1'b0;
    apb_req.pwrite  <= wr;
    apb_req.paddr   <= a;
    apb_req.pwdata  <= d;
    @(posedge clk);
    apb_req.penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
      rdy = apb_rsp.pready;
      rd_q = apb_rsp.prdata;
      err_q = apb_rsp.pslverr;
    end while (rdy !== 1'b1 && n < 20);
    if (rdy !== 1'b1) timeout("apb answer missing");
    apb_req.psel    <= 1'b0;
    apb_req.penable <= 1'b0;
  endtask : apb
  function automatic logic sig(input int s);
    case (s)
      0: return horiz_retrace_out;
      1: return vert_retrace_out;
      2: return dma_request_out;
      3: return cursor_out;
      default: return raster_line_count_out == 4'hf;
    endcase
  endfunction : sig
  task automatic wait_level(input int s, input logic v, input int lim);
    int n;
    n = 0;
    samples_checked++;
    while (sig(s) !== v && n < lim) begin
      @(posedge clk);
      #1;
      n++;
    end
    if (sig(s) !== v) timeout("output level never reached");
  endtask : wait_level
  task automatic width(input int s, output int w);
    @(posedge clk);
    #1;
    wait_level(s, 1'b0, 500);
    wait_level(s, 1'b1, 500);
    w = 0;
    while (sig(s) === 1'b1 && w < 500) begin
      @(posedge clk);
      #1;
      w++;
    end
  endtask : width
  //////////////////////////////////////////////////////////////////////////
  task test_reset_regs;
    apb(1'b0, 12'h004, 32'h0);
    cmp(rd_q, 32'h50180f50, "format0 reset value");
    apb(1'b0, 12'h008, 32'h0);
    cmp(rd_q, 32'h000f0310, "format1 reset value");
    apb(1'b0, 12'h020, 32'h0);
    cmp(rd_q, 32'h0, "unmapped read data");
    cmp(err_q, 1'b1, "unmapped read error");
    apb(1'b1, 12'h002, 32'h1);
    cmp(err_q, 1'b1, "unaligned write");
    $display("done: reset registers");
  endtask : test_reset_regs
  task test_commands;
    for (int m = 0; m < 3; m++) begin
      apb(1'b1, 12'h004, 32'h00010f04 | (m << 24));
      apb(1'b0, 12'h004, 32'h0);
      cmp(rd_q, 32'h00010f04 | (m << 24), "mode readback");
    end
    apb(1'b1, 12'h000, 32'h00000000);
    apb(1'b1, 12'h000, 32'h00000207);
    apb(1'b0, 12'h014, 32'h0);
    cmp(rd_q[3:0], 4'h8, "mask set, display off");
    apb(1'b1, 12'h000, 32'h00000002);
    apb(1'b0, 12'h014, 32'h0);
    cmp(rd_q[0], 1'b1, "start");
    apb(1'b1, 12'h000, 32'h00000001);
    apb(1'b1, 12'h000, 32'h00000005);
    apb(1'b1, 12'h000, 32'h00000006);
    apb(1'b0, 12'h014, 32'h0);
    cmp(rd_q[0], 1'b0, "stop");
    $display("done: commands");
  endtask : test_commands
  task automatic test_display;
    int         w;
    int         nb;
    logic [3:0] seen;
    logic       bad;
    logic       pst;
    logic       prq;
    logic       armed;
    apb(1'b1, 12'h004, 32'h02010f04);
    apb(1'b1, 12'h008, 32'h00000102);
    apb(1'b1, 12'h000, 32'h00000002);
    width(0, w);
    cmp(w, 2, "horizontal retrace length");
    width(1, w);
    cmp(w, 96, "vertical retrace length");
    wait_level(4, 1'b1, 200);
    wait_level(2, 1'b1, 200);
    nb = 0;
    pst = 1'b0;
    prq = 1'b0;
    armed = 1'b0;
    for (int s = 0; s < 2; s++) begin
      slow <= s[0];
      seen = 4'h0;
      bad = 1'b0;
      repeat (600) begin
        @(posedge clk);
        #1;
        if (char_code_out inside {[8'h41:8'h44]})
          seen[2'(char_code_out - 8'h41)] = 1'b1;
        if (char_code_out === 8'h45) bad = 1'b1;
        // each complete fill must take exactly characters-per-row bytes
        if (!dma_request_out & prq & armed & (nb != 4)) bad = 1'b1;
        if (!dma_request_out) begin
          armed = 1'b1;
          nb = 0;
        end else if (dma_strobe_in & ~pst) begin
          nb++;
        end
        pst = dma_strobe_in;
        prq = dma_request_out;
      end
      cmp(seen, 4'hf, "row codes shown");
      cmp(bad, 1'b0, "code beyond row length");
    end
    $display("done: display");
  endtask : test_display
  task automatic test_attributes;
    logic [5:0] v;
    int         hits;
    apb(1'b1, 12'h004, 32'h05010f04);
    code_base <= 8'h7f;
    attr_code <= 8'h3a;
    repeat (300) @(posedge clk);
    hits = 0;
    repeat (300) begin
      @(posedge clk);
      #1;
      v = {general_attr_out, slit_line_twelve_out, slit_line_zero_out,
           video_suppress_out, reverse_video_out, highlight_out};
      if (char_code_out === 8'h7f) cmp(v, 6'h00, "attr before pop");
      if (char_code_out inside {[8'h80:8'h82]}) begin
        hits++;
        cmp(v, 6'h3a, "popped attribute shown");
      end
    end
    cmp(hits > 0, 1'b1, "attribute row shown");
    $display("done: attributes");
  endtask : test_attributes
  task test_cursor;
    apb(1'b1, 12'h000, 32'h00010203);
    apb(1'b0, 12'h00c, 32'h0);
    cmp(rd_q, 32'h00010200, "cursor position");
    wait_level(3, 1'b1, 1000);
    $display("done: cursor");
  endtask : test_cursor
  task test_light_pen;
    @(posedge clk);
    light_pen_in <= 1'b1;
    repeat (4) @(posedge clk);
    light_pen_in <= 1'b0;
    repeat (4) @(posedge clk);
    apb(1'b1, 12'h000, 32'h00000004);
    apb(1'b0, 12'h010, 32'h0);
    cmp(rd_q[16], 1'b1, "pen valid");
    cmp(rd_q[6:0] < 7'd6, 1'b1, "pen column");
    cmp(rd_q[13:8] < 6'd3, 1'b1, "pen row");
    $display("done: light pen");
  endtask : test_light_pen
  //////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (8) @(posedge clk);
    srst <= 1'b0;
    test_reset_regs();
    test_commands();
    test_display();
    test_attributes();
    test_cursor();
    test_light_pen();
    finish_test();
  end
  initial begin
    repeat (60000) @(posedge clk);
    fail("run limit");
    finish_test();
  end
endmodule : crt_row_buffer_video_timing_tb_top
`default_nettype wire
